//--- bench/bso_host.sv
// Behavioural test bus controller for the scan port
`timescale 1ns/1ps
module bso_host (
  input wire logic clk_sys_i,
  input wire logic tdo_i,
  input wire logic tdo_oe_i,
  output logic tck_o = 1'b0,
  output logic tms_o = 1'b1,
  output logic tdi_o = 1'b1
);
  // One 320 ns test clock; tdo read midway through the high phase
  task automatic step(input logic m, input logic d, output logic o);
    tck_o <= 1'b0;
    tms_o <= m;
    tdi_o <= d;
    repeat (4) @(posedge clk_sys_i);
    tck_o <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    o = tdo_oe_i ? tdo_i : 1'b1;
    repeat (2) @(posedge clk_sys_i);
  endtask : step
  // Idle to idle, LSB first; tck stands still afterwards
  task automatic scan(input logic ir, input int n, input logic [17:0] din,
    output logic [17:0] dout);
    logic o;
    dout = '0;
    step(1'b1, !tdi_o, o);
    if (ir) step(1'b1, !tdi_o, o);
    step(1'b0, !tdi_o, o);
    step(1'b0, !tdi_o, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    // Released data line shows the inverse of its last bit
    step(1'b1, !din[n-1], o);
    step(1'b0, !din[n-1], o);
  endtask : scan
endmodule : bso_host

//--- bench/bso_tap_asserts.sv
// Port assertions for the scan port and octal register
`timescale 1ns/1ps
module bso_tap_asserts #(
  parameter int WIDTH = 8
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic tck_i,
  input wire logic double_high_level_i,
  input wire logic norm_clk_i,
  input wire logic oe_n_i,
  input wire logic [WIDTH-1:0] parallel_data_outputs_o,
  input wire logic parallel_data_outputs_oe_o,
  input wire logic tdo_o,
  input wire logic tdo_oe_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  a_reset_outs_off: assert property ($fell(rst_i) |-> !tdo_oe_o && !parallel_data_outputs_oe_o
    && parallel_data_outputs_o == '0) else $error("outputs live after reset");
  a_tdo_on_low: assert property ($rose(tdo_oe_o) |-> !$past(tck_i, 2))
    else $error("tdo on in high phase");
  a_tdo_off_low: assert property (disable iff (rst_i || double_high_level_i)
    $fell(tdo_oe_o) |-> !$past(tck_i, 2)) else $error("tdo off in high phase");
  a_tdo_moves_low: assert property (tdo_oe_o && $changed(tdo_o) |-> !$past(tck_i, 2))
    else $error("tdo moved in high phase");
  // Only test clock edges or a double-high level may move the scan output
  a_quiet_tck_hold: assert property (($stable(tck_i) && !double_high_level_i)[*8]
    |-> $stable(tdo_o) && $stable(tdo_oe_o)) else $error("tdo moved without tck");
  a_dhl_tdo_off: assert property (double_high_level_i[*4] |-> !tdo_oe_o)
    else $error("tdo on in test reset");
  // Drive-from-scan takes over the pins only after a test clock fall
  a_q_needs_clk: assert property ($changed(parallel_data_outputs_o)
    |-> $past(norm_clk_i, 2) || !$past(tck_i, 2)) else $error("q moved without clock");
  a_oe_follows: assert property ($changed(oe_n_i) |-> ##3
    parallel_data_outputs_oe_o == !$past(oe_n_i, 3)) else $error("output enable late");
  c_tdo_on: cover property ($rose(tdo_oe_o));
  c_q_load: cover property ($changed(parallel_data_outputs_o));
  c_dhl: cover property ($fell(double_high_level_i));
endmodule : bso_tap_asserts
bind bso_tap bso_tap_asserts #(.WIDTH(WIDTH)) chk_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
  .tck_i(tck_i), .double_high_level_i(double_high_level_i), .norm_clk_i(norm_clk_i),
  .oe_n_i(oe_n_i), .parallel_data_outputs_o(parallel_data_outputs_o),
  .parallel_data_outputs_oe_o(parallel_data_outputs_oe_o), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o));

//--- bench/tb.sv
// Self-checking bench for the scan port and octal register
`timescale 1ns/1ps
module tb;
  import bso_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic dhl = 1'b0;
  logic nclk = 1'b0;
  logic oe_n = 1'b1;
  logic [7:0] d = 8'h00;
  logic [7:0] q;
  logic tck, tms, tdi, tdo, tdo_oe, q_oe, o;
  logic [17:0] so;
  int miscompares = 0;
  int num_checks = 0;
  always #20 clk_sys_i = ~clk_sys_i;
  bso_host host (.clk_sys_i(clk_sys_i), .tdo_i(tdo), .tdo_oe_i(tdo_oe), .tck_o(tck),
    .tms_o(tms), .tdi_o(tdi));
  bso_tap #(.WIDTH(8)) dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .tck_i(tck), .tms_i(tms),
    .tdi_i(tdi), .double_high_level_i(dhl), .norm_clk_i(nclk), .oe_n_i(oe_n),
    .parallel_data_inputs_i(d), .parallel_data_outputs_o(q),
    .parallel_data_outputs_oe_o(q_oe), .tdo_o(tdo), .tdo_oe_o(tdo_oe));
  task automatic give_verdict();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : wt
  task automatic t_ir_bcr();
    host.scan(1'b1, 8, 18'(IR_BCR_SCAN), so);
    chk("ir capture", 18'(IR_CAPTURE), so);
    host.scan(1'b0, 2, 18'h1, so);
    chk("bcr reset", 18'(BCR_RESET), so);
    host.scan(1'b0, 2, 18'h2, so);
    chk("bcr shift", 18'h1, so);
  endtask : t_ir_bcr
  // Bypass shows a captured zero, then the input delayed by one
  task automatic t_reset_tms();
    host.scan(1'b1, 8, 18'(IR_BCR_SCAN), so);
    for (int i = 0; i < 5; i++) host.step(1'b1, 1'b0, o);
    host.step(1'b0, 1'b0, o);
    host.scan(1'b0, 3, 18'h5, so);
    chk("tms reset", 18'h2, so);
  endtask : t_reset_tms
  task automatic t_dhl();
    host.scan(1'b1, 8, 18'(IR_BCR_SCAN), so);
    dhl <= 1'b1;
    wt(8);
    dhl <= 1'b0;
    wt(1);
    host.step(1'b0, 1'b0, o);
    host.scan(1'b0, 3, 18'h5, so);
    chk("dhl reset", 18'h2, so);
  endtask : t_dhl
  task automatic t_normal();
    oe_n <= 1'b0;
    d <= 8'h3c;
    wt(6);
    chk("q oe on", 18'h1, 18'(q_oe));
    nclk <= 1'b1;
    wt(8);
    nclk <= 1'b0;
    d <= 8'hc3;
    wt(8);
    chk("q hold", 18'h3c, 18'(q));
    oe_n <= 1'b1;
    wt(6);
    chk("q oe off", 18'h0, 18'(q_oe));
  endtask : t_normal
  task automatic t_sample();
    oe_n <= 1'b0;
    d <= 8'ha5;
    wt(6);
    host.scan(1'b1, 8, 18'(IR_SAMPLE), so);
    host.scan(1'b0, 18, 18'h0, so);
    chk("bsr capture", {8'h3c, 8'ha5, 1'b0, 1'b0}, so);
  endtask : t_sample
  // Drive-from-scan: the update stage takes over the outputs
  task automatic t_extest();
    host.scan(1'b0, 18, {8'h96, 8'h00, 1'b1, 1'b0}, so);
    chk("bsr recapture", {8'h3c, 8'ha5, 1'b0, 1'b0}, so);
    host.scan(1'b1, 8, 18'(IR_EXTEST), so);
    chk("extest q", 18'h96, 18'(q));
    chk("extest q oe", 18'h0, 18'(q_oe));
  endtask : t_extest
  initial begin
    wt(50000);
    miscompares++;
    give_verdict();
  end
  initial begin
    wt(12);
    rst_i <= 1'b0;
    wt(3);
    host.step(1'b0, 1'b0, o);
    t_ir_bcr();
    host.scan(1'b1, 8, 18'hff, so);
    host.scan(1'b0, 3, 18'h5, so);
    chk("bypass", 18'h2, so);
    t_reset_tms();
    t_dhl();
    t_normal();
    t_sample();
    t_extest();
    give_verdict();
  end
endmodule : tb

//--- logic/bso_pkg.sv
// Shared constants and types for the boundary-scan octal register test port
package bso_pkg;
  localparam int IR_LEN = 8;
  localparam int BSR_LEN = 18;
  localparam int BCR_LEN = 2;
  localparam int DATA_W = 8;
  localparam int SYNC_STAGES = 2;
  localparam logic [7:0] IR_RESET = 8'hff;
  localparam logic [7:0] IR_CAPTURE = 8'h81;
  localparam logic [1:0] BCR_RESET = 2'h2;
  localparam logic [7:0] IR_EXTEST = 8'h00;
  localparam logic [7:0] IR_SAMPLE = 8'h02;
  localparam logic [7:0] IR_BCR_SCAN = 8'h07;
  localparam int BSR_Q_LSB = 10;
  localparam int BSR_D_LSB = 2;
  localparam int BSR_OE_BIT = 1;
  localparam int BSR_CLK_BIT = 0;

  typedef enum logic [3:0] {
    BSO_RESET = 4'h0,
    BSO_IDLE = 4'h1,
    BSO_SEL_DR = 4'h3,
    BSO_CAP_DR = 4'h2,
    BSO_SHIFT_DR = 4'h6,
    BSO_EXIT1_DR = 4'h7,
    BSO_PAUSE_DR = 4'h5,
    BSO_EXIT2_DR = 4'h4,
    BSO_UPD_DR = 4'hc,
    BSO_SEL_IR = 4'hd,
    BSO_CAP_IR = 4'hf,
    BSO_SHIFT_IR = 4'he,
    BSO_EXIT1_IR = 4'ha,
    BSO_PAUSE_IR = 4'hb,
    BSO_EXIT2_IR = 4'h9,
    BSO_UPD_IR = 4'h8
  } bso_state_e;
endpackage : bso_pkg

//--- logic/bso_sync.sv
// Two-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
module bso_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta;

  // First stage is read only by the second stage
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      meta <= '0;
      q_o <= '0;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule : bso_sync

//--- logic/bso_tap.sv
// Test access port and octal register of the boundary-scan octal register
//
// Function
// - Instructions, test data and test control all travel on four pins: clock, mode, data in, data out; here the double-high level arrives on a fifth input.
// - No test state or test register changes except on a test clock edge; here test reset also changes them without one.
// - Test inputs are sampled on the rising test clock edge and test outputs change on the falling edge.
// - The controller looks only at test clock and mode select to produce all test control; here the double-high level input and rst_i also force its reset state.
// - The mode select level at each rising test clock edge steers the controller state.
// - Serial data in is the only entry for bits shifted into the instruction or selected data register.
// - Serial data out carries the bit leaving the instruction or selected data register while shifting.
// - A double-high level on mode select, seen here as its own input, resets the test logic.
// - The instruction register is eight bits long.
// - There are three data registers: 18-bit boundary scan, 2-bit boundary control, 1-bit bypass.
// - In normal mode each flip-flop loads on a rising normal clock when enable is low, else holds.
// - The controller starts in its reset state and reaches it within five test clocks of mode held high.
// - Test reset sets the instruction register to all ones and the boundary control register to 10.
// - Serial data out turns on at the first falling edge in a shift state, showing the LSB.
`timescale 1ns/1ps
module bso_tap #(
  parameter int WIDTH = bso_pkg::DATA_W
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  input wire logic double_high_level_i,
  input wire logic norm_clk_i,
  input wire logic oe_n_i,
  input wire logic [WIDTH-1:0] parallel_data_inputs_i,
  output logic [WIDTH-1:0] parallel_data_outputs_o,
  output logic parallel_data_outputs_oe_o,
  output logic tdo_o,
  output logic tdo_oe_o
);
  import bso_pkg::*;

  localparam int SYNC_W = WIDTH + 6;

  function automatic bso_state_e tap_next(input bso_state_e cur, input logic mode);
    case (cur)
      BSO_RESET: tap_next = mode ? BSO_RESET : BSO_IDLE;
      BSO_IDLE: tap_next = mode ? BSO_SEL_DR : BSO_IDLE;
      BSO_SEL_DR: tap_next = mode ? BSO_SEL_IR : BSO_CAP_DR;
      BSO_CAP_DR: tap_next = mode ? BSO_EXIT1_DR : BSO_SHIFT_DR;
      BSO_SHIFT_DR: tap_next = mode ? BSO_EXIT1_DR : BSO_SHIFT_DR;
      BSO_EXIT1_DR: tap_next = mode ? BSO_UPD_DR : BSO_PAUSE_DR;
      BSO_PAUSE_DR: tap_next = mode ? BSO_EXIT2_DR : BSO_PAUSE_DR;
      BSO_EXIT2_DR: tap_next = mode ? BSO_UPD_DR : BSO_SHIFT_DR;
      BSO_UPD_DR: tap_next = mode ? BSO_SEL_DR : BSO_IDLE;
      BSO_SEL_IR: tap_next = mode ? BSO_RESET : BSO_CAP_IR;
      BSO_CAP_IR: tap_next = mode ? BSO_EXIT1_IR : BSO_SHIFT_IR;
      BSO_SHIFT_IR: tap_next = mode ? BSO_EXIT1_IR : BSO_SHIFT_IR;
      BSO_EXIT1_IR: tap_next = mode ? BSO_UPD_IR : BSO_PAUSE_IR;
      BSO_PAUSE_IR: tap_next = mode ? BSO_EXIT2_IR : BSO_PAUSE_IR;
      BSO_EXIT2_IR: tap_next = mode ? BSO_UPD_IR : BSO_SHIFT_IR;
      BSO_UPD_IR: tap_next = mode ? BSO_SEL_DR : BSO_IDLE;
      default: tap_next = BSO_RESET;
    endcase
  endfunction : tap_next

  // Pin synchronisation; every pin comes from outside the system clock
  logic [SYNC_W-1:0] sync_q;
  logic tck_s;
  logic tms_s;
  logic tdi_s;
  logic hh_s;
  logic nclk_s;
  logic oe_n_s;
  logic [WIDTH-1:0] din_s;

  bso_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .d_i({parallel_data_inputs_i, oe_n_i, norm_clk_i, double_high_level_i, tdi_i, tms_i,
          tck_i}),
    .q_o(sync_q)
  );

  assign tck_s = sync_q[0];
  assign tms_s = sync_q[1];
  assign tdi_s = sync_q[2];
  assign hh_s = sync_q[3];
  assign nclk_s = sync_q[4];
  assign oe_n_s = sync_q[5];
  assign din_s = sync_q[SYNC_W-1:6];

  // Edge detection on the synchronised clocks
  logic tck_d;
  logic nclk_d;
  wire tck_rise = tck_s & ~tck_d;
  wire tck_fall = ~tck_s & tck_d;
  wire nclk_rise = nclk_s & ~nclk_d;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      // tck_d matches the flushed synchroniser, so no false tck fall follows reset; nclk_d starts high
      tck_d <= 1'b0;
      nclk_d <= 1'b1;
    end else begin
      tck_d <= tck_s;
      nclk_d <= nclk_s;
    end
  end

  // Controller state
  bso_state_e state;
  bso_state_e next_state;
  wire test_reset = rst_i | hh_s;

  assign next_state = tap_next(state, tms_s);

  always_ff @(posedge clk_sys_i) begin
    if (test_reset) begin
      state <= BSO_RESET;
    end else if (tck_rise) begin
      state <= next_state;
    end
  end

  // Registers: shift stages and shadow (update) stages
  logic [IR_LEN-1:0] ir_shift;
  logic [IR_LEN-1:0] ir;
  logic [BSR_LEN-1:0] bsr_shift;
  logic [BSR_LEN-1:0] bsr_upd;
  logic [BCR_LEN-1:0] bcr_shift;
  logic [BCR_LEN-1:0] bcr;
  logic bypass;

  wire sel_bsr = (ir == IR_EXTEST) | (ir == IR_SAMPLE);
  wire sel_bcr = (ir == IR_BCR_SCAN);
  wire test_mode = (ir == IR_EXTEST);
  wire in_shift = (state == BSO_SHIFT_DR) | (state == BSO_SHIFT_IR);

  // Normal register
  logic [WIDTH-1:0] q_reg;
  wire [BSR_LEN-1:0] bsr_capture = {q_reg, din_s, oe_n_s, nclk_s};

  // Instruction register
  always_ff @(posedge clk_sys_i) begin
    if (test_reset || state == BSO_RESET) begin
      ir_shift <= IR_RESET;
      ir <= IR_RESET;
    end else if (tck_rise && state == BSO_CAP_IR) begin
      ir_shift <= IR_CAPTURE;
    end else if (tck_rise && state == BSO_SHIFT_IR) begin
      ir_shift <= {tdi_s, ir_shift[IR_LEN-1:1]};
    end else if (tck_fall && state == BSO_UPD_IR) begin
      ir <= ir_shift;
    end
  end

  // Data registers; bypass is the default path for any other opcode
  always_ff @(posedge clk_sys_i) begin
    if (test_reset || state == BSO_RESET) begin
      bsr_shift <= '0;
      bsr_upd <= '0;
      bcr_shift <= BCR_RESET;
      bcr <= BCR_RESET;
      bypass <= 1'b0;
    end else if (tck_rise && state == BSO_CAP_DR) begin
      if (sel_bsr) begin
        bsr_shift <= bsr_capture;
      end else if (sel_bcr) begin
        bcr_shift <= bcr;
      end else begin
        bypass <= 1'b0;
      end
    end else if (tck_rise && state == BSO_SHIFT_DR) begin
      if (sel_bsr) begin
        bsr_shift <= {tdi_s, bsr_shift[BSR_LEN-1:1]};
      end else if (sel_bcr) begin
        bcr_shift <= {tdi_s, bcr_shift[BCR_LEN-1:1]};
      end else begin
        bypass <= tdi_s;
      end
    end else if (tck_fall && state == BSO_UPD_DR) begin
      if (sel_bsr) begin
        bsr_upd <= bsr_shift;
      end else if (sel_bcr) begin
        bcr <= bcr_shift;
      end
    end
  end

  // Serial output, changed only on the falling test clock or by test reset
  wire dr_lsb = sel_bsr ? bsr_shift[0] : (sel_bcr ? bcr_shift[0] : bypass);
  wire next_tdo = (state == BSO_SHIFT_IR) ? ir_shift[0] : dr_lsb;

  always_ff @(posedge clk_sys_i) begin
    if (test_reset) begin
      tdo_o <= 1'b0;
      tdo_oe_o <= 1'b0;
    end else if (tck_fall) begin
      tdo_o <= next_tdo;
      tdo_oe_o <= in_shift;
    end
  end

  // Normal flip-flops keep running regardless of the test port
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      q_reg <= '0;
    end else if (nclk_rise && !oe_n_s) begin
      q_reg <= din_s;
    end
  end

  // Outputs: in the drive-from-scan mode the update stage takes over the pins
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      parallel_data_outputs_o <= '0;
      parallel_data_outputs_oe_o <= 1'b0;
    end else if (test_mode) begin
      parallel_data_outputs_o <= bsr_upd[BSR_Q_LSB +: WIDTH];
      parallel_data_outputs_oe_o <= ~bsr_upd[BSR_OE_BIT];
    end else begin
      parallel_data_outputs_o <= q_reg;
      parallel_data_outputs_oe_o <= ~oe_n_s;
    end
  end
endmodule : bso_tap
